// ### pkg/reset_cause_pkg.sv
// constants shared by the reset-cause block and its bus front end
package reset_cause_pkg;
  // ****************************************
  // bus and register map (index, byte = 4x)
  // ****************************************
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_PC_LO = 8'h02;
  localparam logic [7:0] IDX_STATUS = 8'h03;
  localparam logic [7:0] IDX_PC_HI = 8'h0A;
  localparam logic [7:0] IDX_IRQC = 8'h0B;
  localparam logic [7:0] IDX_PIRQ = 8'h0C;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_PWRC = 8'h8E;
  localparam logic [7:0] IDX_EVT_STAT = 8'hC0;
  localparam logic [7:0] IDX_EVT_MASK = 8'hC1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // field positions
  // ****************************************
  localparam int ST_TMO = 4;
  localparam int ST_PDN = 3;
  localparam int PW_LPWAKE = 5;
  localparam int PW_SWBRN = 4;
  localparam int PW_POR = 1;
  localparam int PW_BRN = 0;
  localparam int IC_GIRQ = 7;
  localparam logic [7:0] PWR_IMPL = 8'h33;
  localparam logic [7:0] PIRQ_IMPL = 8'h7F;
  localparam logic [7:0] STATUS_SW = 8'hE7;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] STATUS_POR = 8'h18;
  localparam logic [7:0] PWR_RST = 8'h10;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [12:0] PC_STEP = 13'h0001;
  // ****************************************
  // causes and event bits
  // ****************************************
  typedef enum logic [2:0] {
    CAUSE_POR = 3'b000,
    CAUSE_BRN = 3'b001,
    CAUSE_DOG_RST = 3'b010,
    CAUSE_DOG_WAKE = 3'b011,
    CAUSE_MCL_RUN = 3'b100,
    CAUSE_MCL_SLEEP = 3'b101,
    CAUSE_IRQ_WAKE = 3'b110
  } cause_t;
  localparam int EV_W = 6;
  localparam int EV_POR = 0;
  localparam int EV_BRN = 1;
  localparam int EV_DOG_RST = 2;
  localparam int EV_DOG_WAKE = 3;
  localparam int EV_MCL = 4;
  localparam int EV_IRQ_WAKE = 5;
endpackage

// ### design/axil_regs_port.sv
// axi4-lite slave front end handing single-cycle register strobes
`timescale 1ns/1ps
module axil_regs_port #(
  parameter int AW = reset_cause_pkg::ADDR_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [AW-1:0] wr_addr,
  output logic [7:0] wr_data,
  input wire logic wr_ok,
  output logic [AW-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_ok
);
  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic [AW-1:0] aw_r, aw_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic lane0_r, lane0_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic arready_r, arready_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic fire;

  // address and data are held apart, the write fires once both are in
  always_comb begin
    aw_full_nxt = aw_full_r;
    aw_nxt = aw_r;
    w_full_nxt = w_full_r;
    wd_nxt = wd_r;
    lane0_nxt = lane0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    fire = aw_full_r && w_full_r && !bvalid_r;
    if (awvalid && awready_r) begin
      aw_full_nxt = 1'b1;
      aw_nxt = awaddr;
    end
    if (wvalid && wready_r) begin
      w_full_nxt = 1'b1;
      wd_nxt = wdata[7:0];
      lane0_nxt = wstrb[0];
    end
    if (fire) begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_ok ? reset_cause_pkg::RESP_OKAY
                        : reset_cause_pkg::RESP_SLVERR;
    end else if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    // read data is registered here, so one cycle after the address
    if (arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_data;
      rresp_nxt = rd_ok ? reset_cause_pkg::RESP_OKAY
                        : reset_cause_pkg::RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    awready_nxt = !aw_full_nxt && !bvalid_nxt;
    wready_nxt = !w_full_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      aw_r <= '0;
      w_full_r <= 1'b0;
      wd_r <= 8'h00;
      lane0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rresp_r <= 2'h0;
      rdata_r <= 8'h00;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
    end else begin
      aw_full_r <= aw_full_nxt;
      aw_r <= aw_nxt;
      w_full_r <= w_full_nxt;
      wd_r <= wd_nxt;
      lane0_r <= lane0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
    end
  end

  // upper lanes carry nothing; without lane 0 the write is a no-op
  assign wr_en = fire && lane0_r;
  assign wr_addr = aw_r;
  assign wr_data = wd_r;
  assign rd_addr = araddr;
  assign awready = awready_r;
  assign wready = wready_r;
  assign arready = arready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = {24'h000000, rdata_r};
endmodule

// ### design/reset_cause_status.sv
// reset-cause flags, core status and program counter initialisation
`timescale 1ns/1ps
// What this block does
// - four cause flags encode power-on, brown-out, watchdog reset and wake
// - master clear in run mode leaves all four cause flags unchanged
// - master clear in sleep sets timeout, clears powerdown, keeps others
// - brown-out and power-on clear brownout_flag; other resets leave it alone
// - power control: bits 5,4,1,0; 01qq on power/brown-out, 0uuu on other resets, uuuu on wake
// - core status layout; 0001 1xxx, 000q quuu, uuuq quuu per event
// - master clear and watchdog resets take the non-power-up values
// - interrupt wake with global enable jumps to 0004h, else pc + 1
// - interrupt wake sets the flag of the waking source, others kept
// - low supply during any other reset turns it into power-on
// - unimplemented bits read zero; q bits follow the cause
// - resets clear pc low and high latch, set prescaler to all ones
module reset_cause_status (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [reset_cause_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [reset_cause_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cause_valid,
  input wire logic [2:0] cause_code,
  input wire logic supply_low,
  input wire logic wake_src_periph,
  input wire logic [2:0] wake_src_bit,
  output logic irq,
  output logic [12:0] pc_out,
  output logic [7:0] prescale_out
);
  // ****************************************
  // state
  // ****************************************
  logic [7:0] status_r, status_nxt;
  logic [7:0] pwr_r, pwr_nxt;
  logic [12:0] pc_r, pc_nxt;
  logic [4:0] pchi_r, pchi_nxt;
  logic [7:0] option_r, option_nxt;
  logic [7:0] irqc_r, irqc_nxt;
  logic [7:0] pirq_r, pirq_nxt;
  logic [reset_cause_pkg::EV_W-1:0] ev_stat_r, ev_stat_nxt;
  logic [reset_cause_pkg::EV_W-1:0] ev_mask_r, ev_mask_nxt;
  logic [reset_cause_pkg::EV_W-1:0] ev_set, ev_clr;
  logic irq_r, irq_nxt;
  logic wr_en, wr_ok, rd_ok;
  logic [reset_cause_pkg::ADDR_W-1:0] wr_addr, rd_addr;
  logic [7:0] wr_data, rd_data;
  reset_cause_pkg::cause_t cause;

  // word address to register index; upper bits must be zero
  function automatic logic [8:0] reg_index(
    input logic [reset_cause_pkg::ADDR_W-1:0] a
  );
    logic [8:0] r;
    r = 9'h100;
    if (a[1:0] == 2'b00 && a[reset_cause_pkg::ADDR_W-1:10] == '0) begin
      r = {1'b0, a[9:2]};
    end
    return r;
  endfunction

  // whether an index names a register of this block
  function automatic logic is_mapped(input logic [8:0] i);
    return !i[8] && (i[7:0] == reset_cause_pkg::IDX_PC_LO ||
      i[7:0] == reset_cause_pkg::IDX_STATUS ||
      i[7:0] == reset_cause_pkg::IDX_PC_HI ||
      i[7:0] == reset_cause_pkg::IDX_IRQC ||
      i[7:0] == reset_cause_pkg::IDX_PIRQ ||
      i[7:0] == reset_cause_pkg::IDX_OPTION ||
      i[7:0] == reset_cause_pkg::IDX_PWRC ||
      i[7:0] == reset_cause_pkg::IDX_EVT_STAT ||
      i[7:0] == reset_cause_pkg::IDX_EVT_MASK);
  endfunction

  // ****************************************
  // bus front end
  // ****************************************
  axil_regs_port #(.AW(reset_cause_pkg::ADDR_W)) u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // ****************************************
  // read mux
  // ****************************************
  // unimplemented bits are masked to zero on the way out
  always_comb begin
    logic [8:0] ri;
    ri = reg_index(rd_addr);
    rd_ok = is_mapped(ri);
    rd_data = 8'h00;
    unique case (ri)
      {1'b0, reset_cause_pkg::IDX_PC_LO}: rd_data = pc_r[7:0];
      {1'b0, reset_cause_pkg::IDX_STATUS}: rd_data = status_r;
      {1'b0, reset_cause_pkg::IDX_PC_HI}: rd_data = {3'b000, pchi_r};
      {1'b0, reset_cause_pkg::IDX_IRQC}: rd_data = irqc_r;
      {1'b0, reset_cause_pkg::IDX_PIRQ}:
        rd_data = pirq_r & reset_cause_pkg::PIRQ_IMPL;
      {1'b0, reset_cause_pkg::IDX_OPTION}: rd_data = option_r;
      {1'b0, reset_cause_pkg::IDX_PWRC}:
        rd_data = pwr_r & reset_cause_pkg::PWR_IMPL;
      {1'b0, reset_cause_pkg::IDX_EVT_STAT}: rd_data = {2'b00, ev_stat_r};
      {1'b0, reset_cause_pkg::IDX_EVT_MASK}: rd_data = {2'b00, ev_mask_r};
      default: rd_data = 8'h00;
    endcase
  end

  // ****************************************
  // register and cause update
  // ****************************************
  // software writes first, a same-cycle event then overrides them
  always_comb begin
    logic [8:0] wi;
    logic hw;
    wi = reg_index(wr_addr);
    wr_ok = is_mapped(wi);
    hw = wr_en && wr_ok;
    status_nxt = status_r;
    pwr_nxt = pwr_r;
    pc_nxt = pc_r;
    pchi_nxt = pchi_r;
    option_nxt = option_r;
    irqc_nxt = irqc_r;
    pirq_nxt = pirq_r;
    ev_mask_nxt = ev_mask_r;
    ev_set = '0;
    ev_clr = '0;
    cause = reset_cause_pkg::cause_t'(cause_code);
    if (hw) begin
      unique case (wi[7:0])
        reset_cause_pkg::IDX_PC_LO: pc_nxt = {pchi_r, wr_data};
        // timeout and powerdown are hardware-only bits
        reset_cause_pkg::IDX_STATUS:
          status_nxt = (status_r & ~reset_cause_pkg::STATUS_SW) |
                       (wr_data & reset_cause_pkg::STATUS_SW);
        reset_cause_pkg::IDX_PC_HI: pchi_nxt = wr_data[4:0];
        reset_cause_pkg::IDX_IRQC: irqc_nxt = wr_data;
        reset_cause_pkg::IDX_PIRQ:
          pirq_nxt = wr_data & reset_cause_pkg::PIRQ_IMPL;
        reset_cause_pkg::IDX_OPTION: option_nxt = wr_data;
        reset_cause_pkg::IDX_PWRC:
          pwr_nxt = wr_data & reset_cause_pkg::PWR_IMPL;
        reset_cause_pkg::IDX_EVT_STAT: ev_clr = wr_data[5:0];
        reset_cause_pkg::IDX_EVT_MASK: ev_mask_nxt = wr_data[5:0];
        default: ;
      endcase
    end
    // a low supply turns any reset (not a wake) into power-on
    // code 7 is no reset, so a sagging supply must not promote it
    if (cause_valid && supply_low && (cause == reset_cause_pkg::CAUSE_BRN ||
        cause == reset_cause_pkg::CAUSE_DOG_RST ||
        cause == reset_cause_pkg::CAUSE_MCL_RUN ||
        cause == reset_cause_pkg::CAUSE_MCL_SLEEP)) begin
      cause = reset_cause_pkg::CAUSE_POR;
    end
    // one update per event pulse, held until written again
    if (cause_valid) begin
      unique case (cause)
        reset_cause_pkg::CAUSE_POR: begin
          status_nxt = reset_cause_pkg::STATUS_POR;
          pwr_nxt = reset_cause_pkg::PWR_RST; // por = 0
          ev_set[reset_cause_pkg::EV_POR] = 1'b1;
        end
        reset_cause_pkg::CAUSE_BRN: begin
          status_nxt = {3'b000, 2'b11, status_r[2:0]};
          pwr_nxt = reset_cause_pkg::PWR_RST;
          pwr_nxt[reset_cause_pkg::PW_POR] =
            pwr_r[reset_cause_pkg::PW_POR];
          pwr_nxt[reset_cause_pkg::PW_BRN] = 1'b0;
          ev_set[reset_cause_pkg::EV_BRN] = 1'b1;
        end
        reset_cause_pkg::CAUSE_DOG_RST: begin
          status_nxt = {3'b000, 1'b0, status_r[3:0]};
          pwr_nxt[reset_cause_pkg::PW_LPWAKE] = 1'b0;
          ev_set[reset_cause_pkg::EV_DOG_RST] = 1'b1;
        end
        reset_cause_pkg::CAUSE_MCL_RUN: begin
          status_nxt = {3'b000, status_r[4:0]};
          pwr_nxt[reset_cause_pkg::PW_LPWAKE] = 1'b0;
          ev_set[reset_cause_pkg::EV_MCL] = 1'b1;
        end
        reset_cause_pkg::CAUSE_MCL_SLEEP: begin
          status_nxt = {3'b000, 2'b10, status_r[2:0]};
          pwr_nxt[reset_cause_pkg::PW_LPWAKE] = 1'b0;
          ev_set[reset_cause_pkg::EV_MCL] = 1'b1;
        end
        reset_cause_pkg::CAUSE_DOG_WAKE: begin
          status_nxt[reset_cause_pkg::ST_TMO] = 1'b0;
          status_nxt[reset_cause_pkg::ST_PDN] = 1'b0;
          ev_set[reset_cause_pkg::EV_DOG_WAKE] = 1'b1;
        end
        reset_cause_pkg::CAUSE_IRQ_WAKE: begin
          // interrupt wake sets timeout and clears powerdown
          status_nxt[reset_cause_pkg::ST_TMO] = 1'b1;
          status_nxt[reset_cause_pkg::ST_PDN] = 1'b0;
          ev_set[reset_cause_pkg::EV_IRQ_WAKE] = 1'b1;
        end
        default: ;
      endcase
      unique case (cause)
        reset_cause_pkg::CAUSE_DOG_WAKE,
        reset_cause_pkg::CAUSE_IRQ_WAKE: begin
          if (cause == reset_cause_pkg::CAUSE_IRQ_WAKE &&
              irqc_r[reset_cause_pkg::IC_GIRQ]) begin
            pc_nxt = reset_cause_pkg::IRQ_VECTOR;
          end else begin
            pc_nxt = pc_r + reset_cause_pkg::PC_STEP;
          end
          // the waking source leaves its flag behind
          if (cause == reset_cause_pkg::CAUSE_IRQ_WAKE) begin
            if (wake_src_periph) begin
              pirq_nxt[wake_src_bit] = 1'b1;
              pirq_nxt = pirq_nxt & reset_cause_pkg::PIRQ_IMPL;
            end else begin
              irqc_nxt[wake_src_bit] = 1'b1;
            end
          end
        end
        reset_cause_pkg::CAUSE_POR, reset_cause_pkg::CAUSE_BRN,
        reset_cause_pkg::CAUSE_DOG_RST, reset_cause_pkg::CAUSE_MCL_RUN,
        reset_cause_pkg::CAUSE_MCL_SLEEP: begin
          pc_nxt = reset_cause_pkg::PC_RST;
          pchi_nxt = 5'h00;
          option_nxt = reset_cause_pkg::OPTION_RST;
          irqc_nxt = {7'h00, irqc_r[0]};
          pirq_nxt = reset_cause_pkg::ZERO8;
        end
        default: ;
      endcase
    end
    // sticky event bits: a set wins over a same-cycle clear
    ev_stat_nxt = (ev_stat_r & ~ev_clr) | ev_set;
    irq_nxt = |(ev_stat_nxt & ev_mask_nxt);
  end

  // aresetn behaves as a power-on with no event recorded
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= reset_cause_pkg::STATUS_POR;
      pwr_r <= reset_cause_pkg::PWR_RST;
      pc_r <= reset_cause_pkg::PC_RST;
      pchi_r <= 5'h00;
      option_r <= reset_cause_pkg::OPTION_RST;
      irqc_r <= reset_cause_pkg::ZERO8;
      pirq_r <= reset_cause_pkg::ZERO8;
      ev_stat_r <= '0;
      ev_mask_r <= '0;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      pwr_r <= pwr_nxt;
      pc_r <= pc_nxt;
      pchi_r <= pchi_nxt;
      option_r <= option_nxt;
      irqc_r <= irqc_nxt;
      pirq_r <= pirq_nxt;
      ev_stat_r <= ev_stat_nxt;
      ev_mask_r <= ev_mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign irq = irq_r;
  assign pc_out = pc_r;
  assign prescale_out = option_r;
endmodule

// ### test/reset_cause_sva.sv
// concurrent checks on the reset-cause block ports
`timescale 1ns/1ps
module reset_cause_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic cause_valid,
  input wire logic [2:0] cause_code,
  input wire logic [12:0] pc_out,
  input wire logic [7:0] prescale_out
);
  // ****
  // one clock domain, one synchronous reset
  // ****
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_pc_init: assert property (
    cause_valid && cause_code inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5}
    |=> pc_out == 13'h0000 && prescale_out == 8'hFF)
    else $error("reset left pc or prescaler");
  a_wd_wake_step: assert property (
    cause_valid && cause_code == 3'h3 |=> pc_out == $past(pc_out) + 13'h0001)
    else $error("watchdog wake did not step pc");
  a_irq_wake_pc: assert property (
    cause_valid && cause_code == 3'h6
    |=> pc_out == 13'h0004 || pc_out == $past(pc_out) + 13'h0001)
    else $error("interrupt wake pc wrong");
  // a second reset also reloads the prescaler, hence the reset term
  a_prescale_hold: assert property (
    $changed(prescale_out)
    |-> $past(cause_valid) || $rose(s_axi_bvalid) || !$past(aresetn))
    else $error("prescaler moved on its own");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("unused read bits not zero");
  a_busy_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
endmodule

bind reset_cause_status reset_cause_sva i_sva (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rdata, .cause_valid, .cause_code, .pc_out, .prescale_out);

// ### test/reset_cause_status_bench.sv
// self-checking bench for the reset-cause block
`timescale 1ns/1ps
module reset_cause_status_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, cause_valid;
  logic supply_low, wake_src_periph, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0] cause_code, wake_src_bit;
  logic [12:0] pc_out, pc_e;
  logic [7:0] prescale_out, st_e, pw_e, op_e, lat_e, mk_e;
  logic [15:0] rnd;
  int miscompares, checked;
  reset_cause_status i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cause_valid, .cause_code, .supply_low,
    .wake_src_periph, .wake_src_bit, .irq, .pc_out, .prescale_out);
  // 100 MHz clock
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  // hang guard, far above a normal run
  initial begin
    repeat (50000) @(posedge aclk);
    miscompares++;
    summarize();
  end
  // ****
  // expectation functions
  // ****
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // a sagging supply turns any reset into power-on
  function automatic logic [2:0] eff(input logic [2:0] c, input logic sl);
    return (sl && c inside {3'h1, 3'h2, 3'h4, 3'h5}) ? 3'h0 : c;
  endfunction
  function automatic logic [7:0] st_next(input logic [2:0] c,
      input logic [7:0] s);
    case (c)
      3'h0, 3'h1: return {5'h03, s[2:0]};
      3'h2: return {4'h0, s[3:0]};
      3'h3: return {s[7:5], 2'h0, s[2:0]};
      3'h4: return {3'h0, s[4:0]};
      3'h5: return {3'h0, 2'h2, s[2:0]};
      3'h6: return {s[7:5], 2'h2, s[2:0]};
      default: return s;
    endcase
  endfunction
  function automatic logic [7:0] pw_next(input logic [2:0] c,
      input logic [7:0] p);
    case (c)
      3'h0: return 8'h10;
      3'h1: return {6'h04, p[1], 1'h0};
      3'h2, 3'h4, 3'h5: return {3'h0, p[4:0]};
      default: return p;
    endcase
  endfunction
  // ****
  // compare, verdict and bus tasks
  // ****
  task automatic cmp(input string n, input logic [31:0] e,
      input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v,
      input logic [3:0] sb, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= sb;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        return;
      end
    end
    miscompares++;
    summarize();
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v,
      output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) begin
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        return;
      end
    end
    miscompares++;
    summarize();
  endtask
  task automatic wreg(input logic [7:0] i, input logic [7:0] v);
    wr({2'h0, i, 2'h0}, v, 4'hF, rsp);
    cmp("wresp", 32'h0, {30'h0, rsp});
  endtask
  // masked read-back; upper word bits must stay zero
  task automatic rchk(input string n, input logic [7:0] i,
      input logic [7:0] e, input logic [7:0] m);
    rd({2'h0, i, 2'h0}, q, rsp);
    cmp(n, {24'h0, e & m}, q & {24'hFFFFFF, m});
  endtask
  // random state, one cause event, then its effects compared, irqc and pirq on interrupt wake only
  task automatic do_ev(input logic [2:0] c, input logic sl);
    logic [2:0] e, b;
    logic g, per;
    logic [7:0] ic, evb;
    e = eff(c, sl);
    rnd = lfsr(rnd);
    g = rnd[13];
    per = rnd[14];
    b = per ? rnd[2:0] % 3'h7 : rnd[2:0] % 3'h3;
    ic = {g, 7'h0};
    st_e = (st_e & 8'h18) | (rnd[7:0] & 8'hE7);
    pw_e = rnd[15:8] & 8'h33;
    op_e = rnd[11:4];
    lat_e = {3'h0, rnd[12:8]};
    pc_e = rnd[12:0];
    wreg(reset_cause_pkg::IDX_STATUS, rnd[7:0]);
    wreg(reset_cause_pkg::IDX_PWRC, rnd[15:8]);
    wreg(reset_cause_pkg::IDX_OPTION, op_e);
    wreg(reset_cause_pkg::IDX_PC_HI, lat_e);
    wreg(reset_cause_pkg::IDX_PC_LO, rnd[7:0]);
    wreg(reset_cause_pkg::IDX_IRQC, ic);
    wreg(reset_cause_pkg::IDX_PIRQ, 8'h00);
    cmp("irq idle", 32'h0, {31'h0, irq});
    @(posedge aclk);
    cause_valid <= 1'h1;
    cause_code <= c;
    supply_low <= sl;
    wake_src_periph <= per;
    wake_src_bit <= b;
    @(posedge aclk);
    cause_valid <= 1'h0;
    st_e = st_next(e, st_e);
    pw_e = pw_next(e, pw_e);
    evb = (e == 3'h7) ? 8'h00 : 8'h01 << (e > 3'h4 ? e - 3'h1 : e);
    if (e inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5}) begin
      pc_e = 13'h0000;
      op_e = 8'hFF;
      lat_e = 8'h00;
    end else if (e == 3'h3 || e == 3'h6) begin
      pc_e = (e == 3'h6 && g) ? 13'h0004 : pc_e + 13'h0001;
    end
    // power-on leaves the arithmetic flags open, so they are masked
    rchk("status", reset_cause_pkg::IDX_STATUS, st_e,
      e == 3'h0 ? 8'hF8 : 8'hFF);
    rchk("pwrc", reset_cause_pkg::IDX_PWRC, pw_e, 8'hFF);
    rchk("pchi", reset_cause_pkg::IDX_PC_HI, lat_e, 8'hFF);
    rchk("option", reset_cause_pkg::IDX_OPTION, op_e, 8'hFF);
    cmp("pc", {19'h0, pc_e}, {19'h0, pc_out});
    cmp("prescale", {24'h0, op_e}, {24'h0, prescale_out});
    if (e == 3'h6) begin
      rchk("irqc", reset_cause_pkg::IDX_IRQC,
        per ? ic : ic | 8'h01 << b, 8'hFF);
      rchk("pirq", reset_cause_pkg::IDX_PIRQ,
        per ? 8'h01 << b : 8'h00, 8'hFF);
    end
    rchk("events", reset_cause_pkg::IDX_EVT_STAT, evb, 8'h3F);
    cmp("irq", {31'h0, |(evb & mk_e)}, {31'h0, irq});
    wreg(reset_cause_pkg::IDX_EVT_STAT, 8'hFF);
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    aresetn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, cause_valid, supply_low, wake_src_periph} = 4'h0;
    s_axi_awaddr = 12'h0;
    s_axi_araddr = 12'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    cause_code = 3'h0;
    wake_src_bit = 3'h0;
    miscompares = 0;
    checked = 0;
    rnd = 16'h002A;
    st_e = 8'h18;
    mk_e = 8'h00;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    cmp("pc", 32'h0, {19'h0, pc_out});
    cmp("prescale", 32'hFF, {24'h0, prescale_out});
    // misaligned write must not reach the status register
    wr(12'h00D, 8'h5A, 4'hF, rsp);
    cmp("misaligned resp", 32'h2, {30'h0, rsp});
    rchk("status", reset_cause_pkg::IDX_STATUS, 8'h18, 8'hFF);
    rchk("pwrc", reset_cause_pkg::IDX_PWRC, 8'h10, 8'hFF);
    rchk("pirq", reset_cause_pkg::IDX_PIRQ, 8'h00, 8'hFF);
    rd(12'hFF0, q, rsp);
    cmp("unmapped data", 32'h0, q);
    cmp("unmapped resp", 32'h2, {30'h0, rsp});
    // unused bits read zero; a strobe-less write is dropped
    wreg(reset_cause_pkg::IDX_PWRC, 8'hFF);
    wr({2'h0, reset_cause_pkg::IDX_PWRC, 2'h0}, 8'h00, 4'h0, rsp);
    rchk("pwrc", reset_cause_pkg::IDX_PWRC, 8'h33, 8'hFF);
    // every cause, steady supply then sagging, interrupt masked
    for (int i = 0; i < 16; i++) do_ev(i[2:0], i[3]);
    // random causes under random interrupt masks
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr(rnd);
      mk_e = rnd[15:8];
      wreg(reset_cause_pkg::IDX_EVT_MASK, mk_e);
      do_ev(rnd[2:0], rnd[3] & rnd[4]);
    end
    summarize();
  end
endmodule
